// ===== include/ebu_pkg.sv
// Purpose: shared constants and types for the address map and bus unit
// Assumes: 24-bit byte addresses, 16-bit data
// Notes: segment 0 layout below the register areas is a fixed choice
package ebu_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int WIN_NUM = 4;
  localparam int WAIT_W = 4;
  // linear map boundaries
  localparam logic [23:0] EXT_LOW_END = 24'h007FFF;
  localparam logic [23:0] SEG0_END = 24'h00FFFF;
  localparam logic [23:0] EXT_MID_END = 24'h1FFFFF;
  localparam logic [23:0] EXT_IO_START = 24'h200800;
  localparam logic [23:0] EXT_IO_END = 24'h3FFFFF;
  localparam logic [23:0] EXT_HIGH_END = 24'hBEFFFF;
  localparam logic [23:0] FLASH_START = 24'hC00000;
  localparam logic [23:0] FLASH_END = 24'hC1FFFF;
  localparam logic [23:0] PROG_RSV_END = 24'hDFFFFF;
  localparam logic [23:0] PROGRAM_SRAM_START = 24'hE00000;
  localparam logic [23:0] PROGRAM_SRAM_END = 24'hE007FF;
  localparam logic [23:0] FLASH_REG_START = 24'hFFF000;
  // segment 0 internal areas
  localparam logic [23:0] DATA_SRAM_START = 24'h00C000;
  localparam logic [23:0] DATA_SRAM_END = 24'h00CFFF;
  localparam logic [23:0] EXTENDED_REGISTER_SPACE_START = 24'h00F000;
  localparam logic [23:0] EXTENDED_REGISTER_SPACE_END = 24'h00F1FF;
  localparam logic [23:0] DUAL_PORT_RAM_START = 24'h00F600;
  localparam logic [23:0] DUAL_PORT_RAM_BIT_START = 24'h00FD00;
  localparam logic [23:0] DUAL_PORT_RAM_END = 24'h00FDFF;
  localparam logic [23:0] SFR_START = 24'h00FE00;
  // defined flash registers from FLASH_REG_START upward, in bytes
  localparam logic [11:0] FLASH_REG_USED_DEFAULT = 12'h100;
  // value returned on a trapped read; arbitrary value
  localparam logic [15:0] TRAP_CODE_DEFAULT = 16'h5A5A;
  localparam logic [15:0] RDATA_RST = 16'h0000;
  localparam logic [2:0] WIN_DEFAULT = 3'h0;

  typedef enum logic [3:0] {
    TGT_EXT, TGT_EXT_IO, TGT_SFR, TGT_EXTENDED_REGISTER_SPACE, TGT_DUAL_PORT_RAM, TGT_DATA_SRAM,
    TGT_FLASH, TGT_PROGRAM_SRAM, TGT_FLASH_REG, TGT_TRAP
  } target_type;

  typedef enum logic [1:0] {
    ST_IDLE, ST_ADDR, ST_STROBE, ST_HOLD
  } bus_state_type;
endpackage : ebu_pkg

// ===== hw/addr_map_ebu.sv
// Purpose: address decode and external bus unit of a 16-bit controller
// Assumes: internal memories answer I_INT_RDATA in the request cycle
// Notes: external pins change on rising edges of O_BUS_REF_CLK
`timescale 1ns/1ps

// Behaviour
// - 16 MB space, 256 segments, 16K pages
// - byte and word access everywhere
// - internal data memories and register areas in segment 0
// - two 512-byte word register areas
// - dual-port RAM bit addressing flags
// - external ranges become external bus cycles
// - flash from C0'0000, C2..DF reserved
// - undefined flash register reads return trap
// - external IO range disables pipeline optimization
// - single chip plus four external modes
// - demux address on second port
// - segment lines on fourth port, count programmable
// - four selects: three windows plus default
// - per-select timing and function settings
// - windows resolved by priority
// - unmatched access uses select zero settings
// - active window selects; window 4 internal
// - bus timing tied to reference clock rise
// - bus mode switched per access
// - local peripheral bus served alike
module addr_map_ebu
  import ebu_pkg::*;
#(
  parameter logic [15:0] TRAP_CODE = TRAP_CODE_DEFAULT,
  parameter logic [11:0] FLASH_REG_USED = FLASH_REG_USED_DEFAULT
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic I_REQ,
  input wire logic [23:0] I_ADDR,
  input wire logic I_WRITE,
  input wire logic I_BYTE,
  input wire logic I_GPR_ACCESS,
  input wire logic I_LOCAL_BUS,
  input wire logic [15:0] I_WDATA,
  input wire logic [15:0] I_INT_RDATA,
  input wire logic I_SINGLE_CHIP,
  input wire logic [2:0] I_SEG_LINES,
  input wire logic [3:0] I_WIN_ENABLE,
  input wire logic [47:0] I_WIN_BASE,
  input wire logic [47:0] I_WIN_MASK,
  input wire logic [19:0] I_TIMING_SET,
  input wire logic [9:0] I_FUNCTION_SET,
  input wire logic [15:0] I_ADDR_DATA_PORT,
  input wire logic [15:0] I_LOCAL_BUS_RDATA,
  output logic O_READY,
  output logic O_ACK,
  output logic O_TRAP,
  output logic [15:0] O_RDATA,
  output logic [3:0] O_TARGET,
  output logic O_BIT_ADDRESSABLE,
  output logic O_NO_PIPE_OPT,
  output logic [15:0] O_ADDR_DATA_PORT,
  output logic [15:0] O_ADDR_DATA_PORT_OE,
  output logic [15:0] O_ADDRESS_PORT,
  output logic [7:0] O_SEG_PORT,
  output logic [7:0] O_SEG_PORT_OE,
  output logic [3:0] O_CS_N,
  output logic O_ALE,
  output logic O_RD_N,
  output logic O_WR_N,
  output logic O_BHE_N,
  output logic O_BUS_REF_CLK,
  output logic O_LOCAL_BUS_SEL,
  output logic O_LOCAL_BUS_RD,
  output logic O_LOCAL_BUS_WR,
  output logic [23:0] O_LOCAL_BUS_ADDR,
  output logic [15:0] O_LOCAL_BUS_WDATA
);

  // linear map decode; segment 0 holds all internal data areas
  function automatic target_type decode_target(input logic [23:0] a);
    target_type t;
    t = TGT_TRAP;
    if (a <= EXT_LOW_END) t = TGT_EXT;
    else if (a <= SEG0_END) begin
      if (a >= SFR_START) t = TGT_SFR;
      else if (a >= DUAL_PORT_RAM_START && a <= DUAL_PORT_RAM_END) t = TGT_DUAL_PORT_RAM;
      else if (a >= EXTENDED_REGISTER_SPACE_START && a <= EXTENDED_REGISTER_SPACE_END) t = TGT_EXTENDED_REGISTER_SPACE;
      else if (a >= DATA_SRAM_START && a <= DATA_SRAM_END) t = TGT_DATA_SRAM;
    end
    else if (a <= EXT_MID_END) t = TGT_EXT;
    else if (a >= EXT_IO_START && a <= EXT_IO_END) t = TGT_EXT_IO;
    else if (a > EXT_IO_END && a <= EXT_HIGH_END) t = TGT_EXT;
    else if (a >= FLASH_START && a <= FLASH_END) t = TGT_FLASH;
    else if (a >= PROGRAM_SRAM_START && a <= PROGRAM_SRAM_END) t = TGT_PROGRAM_SRAM;
    else if (a >= FLASH_REG_START) t = TGT_FLASH_REG;
    return t; // everything else, C2..DF included, traps
  endfunction : decode_target

  // highest numbered hit wins, zero means default select
  function automatic logic [2:0] pick_window(input logic [23:0] a);
    logic [2:0] w;
    w = WIN_DEFAULT;
    for (int i = 0; i < WIN_NUM; i++) begin
      if (I_WIN_ENABLE[i] && ((a[23:12] & I_WIN_MASK[i*12 +: 12]) ==
          (I_WIN_BASE[i*12 +: 12] & I_WIN_MASK[i*12 +: 12]))) begin
        w = 3'(i + 1);
      end
    end
    return w;
  endfunction : pick_window

  bus_state_type state_reg, state_next;
  logic [23:0] addr_reg, addr_next;
  logic [15:0] wdata_reg, wdata_next;
  logic [15:0] rdata_reg, rdata_next;
  logic write_reg, write_next;
  logic byte_reg, byte_next;
  logic [2:0] win_reg, win_next;
  logic mode8_reg, mode8_next;
  logic mux_reg, mux_next;
  logic [WAIT_W-1:0] wait_reg, wait_next;
  logic [WAIT_W-1:0] cnt_reg, cnt_next;
  logic phase_reg, phase_next;
  logic local_reg, local_next;
  logic ack_reg, ack_next;
  logic trap_reg, trap_next;
  target_type target_reg, target_next;
  logic bit_reg, bit_next;
  logic io_reg, io_next;
  logic ref_reg, ref_next;
  logic ale_reg, ale_next;
  logic rd_n_reg, rd_n_next;
  logic wr_n_reg, wr_n_next;
  logic bhe_n_reg, bhe_n_next;
  logic [3:0] cs_n_reg, cs_n_next;
  logic [15:0] ad_reg, ad_next;
  logic [15:0] ad_oe_reg, ad_oe_next;
  logic [15:0] aport_reg, aport_next;
  logic [7:0] seg_reg, seg_next;
  logic [7:0] seg_oe_reg, seg_oe_next;
  logic lb_sel_reg, lb_sel_next;
  logic lb_rd_reg, lb_rd_next;
  logic lb_wr_reg, lb_wr_next;
  logic [15:0] ad_sync1_reg, ad_sync2_reg, ad_sync3_reg;
  logic [15:0] ad_filt_reg, ad_filt_next;

  // pin data settles only once the last two stages agree
  always_comb begin
    ad_filt_next = ad_filt_reg;
    if (ad_sync2_reg == ad_sync3_reg) ad_filt_next = ad_sync3_reg;
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      ad_sync1_reg <= RDATA_RST;
      ad_sync2_reg <= RDATA_RST;
      ad_sync3_reg <= RDATA_RST;
      ad_filt_reg <= RDATA_RST;
    end else begin
      ad_sync1_reg <= I_ADDR_DATA_PORT;
      ad_sync2_reg <= ad_sync1_reg;
      ad_sync3_reg <= ad_sync2_reg;
      ad_filt_reg <= ad_filt_next;
    end
  end

  // access sequencer plus registered pin values
  always_comb begin
    target_type tgt;
    logic edge_en, ext, busy;
    logic [23:0] lane;
    logic [15:0] src;
    logic [7:0] seg_mask;
    tgt = decode_target(I_ADDR);
    edge_en = !ref_reg; // next edge is a reference rise
    ext = (tgt == TGT_EXT) || (tgt == TGT_EXT_IO);
    src = local_reg ? I_LOCAL_BUS_RDATA : ad_filt_reg;
    seg_mask = 8'((9'h001 << I_SEG_LINES) - 9'h001);
    busy = 1'b0;
    lane = addr_reg;
    state_next = state_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    write_next = write_reg;
    byte_next = byte_reg;
    win_next = win_reg;
    mode8_next = mode8_reg;
    mux_next = mux_reg;
    wait_next = wait_reg;
    cnt_next = cnt_reg;
    phase_next = phase_reg;
    local_next = local_reg;
    target_next = target_reg;
    bit_next = bit_reg;
    io_next = io_reg;
    ack_next = 1'b0;
    trap_next = 1'b0;
    ref_next = ~ref_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (I_REQ) begin
          addr_next = I_ADDR;
          wdata_next = I_WDATA;
          write_next = I_WRITE;
          byte_next = I_BYTE;
          target_next = tgt;
          bit_next = (tgt == TGT_DUAL_PORT_RAM) &&
                     (I_GPR_ACCESS || I_ADDR >= DUAL_PORT_RAM_BIT_START);
          if (I_LOCAL_BUS || (ext && !I_SINGLE_CHIP)) begin
            win_next = I_LOCAL_BUS ? WIN_DEFAULT : pick_window(I_ADDR);
            wait_next = I_TIMING_SET[win_next*4 +: 4];
            mode8_next = !I_LOCAL_BUS &&
                         I_FUNCTION_SET[win_next*2 + 1];
            mux_next = I_FUNCTION_SET[win_next*2];
            local_next = I_LOCAL_BUS;
            io_next = !I_LOCAL_BUS && (tgt == TGT_EXT_IO);
            phase_next = 1'b0;
            state_next = ST_ADDR;
          end else begin
            // internal or trapped access answers next cycle
            ack_next = 1'b1;
            trap_next = ext || (tgt == TGT_TRAP) ||
                        ((tgt == TGT_FLASH_REG) && !I_WRITE &&
                         (I_ADDR[11:0] >= FLASH_REG_USED));
            if (!I_WRITE) rdata_next = trap_next ? TRAP_CODE : I_INT_RDATA;
          end
        end
      end
      ST_ADDR: begin
        // the address phase must have reached the pins before the strobe
        if (edge_en && (ale_reg || local_reg)) begin
          state_next = ST_STROBE;
          cnt_next = wait_reg;
        end
      end
      ST_STROBE: begin
        if (edge_en) begin
          if (cnt_reg != '0) cnt_next = cnt_reg - 1'b1;
          else begin
            if (!write_reg) begin
              if (mode8_reg && phase_reg) rdata_next[15:8] = src[7:0];
              else if (mode8_reg) rdata_next = {8'h00, src[7:0]};
              else if (byte_reg && addr_reg[0])
                rdata_next = {8'h00, src[15:8]};
              else if (byte_reg) rdata_next = {8'h00, src[7:0]};
              else rdata_next = src;
            end
            // a word over an 8-bit bus takes a second byte cycle
            if (mode8_reg && !byte_reg && !phase_reg) begin
              phase_next = 1'b1;
              state_next = ST_ADDR;
            end else state_next = ST_HOLD;
          end
        end
      end
      ST_HOLD: begin
        if (edge_en) begin
          state_next = ST_IDLE;
          ack_next = 1'b1;
          io_next = 1'b0;
        end
      end
    endcase
    // pin values follow the next state so they move with the clock rise
    busy = (state_next != ST_IDLE) && !local_next;
    lane = {addr_next[23:1], addr_next[0] | phase_next};
    cs_n_next = 4'hF;
    if (busy && win_next != 3'h4) cs_n_next[win_next[1:0]] = 1'b0;
    ale_next = busy && (state_next == ST_ADDR);
    rd_n_next = !(busy && state_next == ST_STROBE && !write_next);
    wr_n_next = !(busy && state_next == ST_STROBE && write_next);
    bhe_n_next = !(busy && !mode8_next && (!byte_next || lane[0]));
    aport_next = (busy && !mux_next) ? lane[15:0] : 16'h0000;
    ad_next = 16'h0000;
    ad_oe_next = 16'h0000;
    if (ale_next && mux_next) begin
      ad_next = lane[15:0];
      ad_oe_next = 16'hFFFF;
    end else if (!wr_n_next) begin
      if (mode8_next) begin
        ad_next = {8'h00, phase_next ? wdata_next[15:8] : wdata_next[7:0]};
        ad_oe_next = 16'h00FF;
      end else begin
        ad_next = byte_next ? {2{wdata_next[7:0]}} : wdata_next;
        ad_oe_next = 16'hFFFF;
      end
    end
    seg_next = busy ? (lane[23:16] & seg_mask) : 8'h00;
    seg_oe_next = I_SINGLE_CHIP ? 8'h00 : seg_mask;
    lb_sel_next = (state_next != ST_IDLE) && local_next;
    lb_rd_next = lb_sel_next && state_next == ST_STROBE && !write_next;
    lb_wr_next = lb_sel_next && state_next == ST_STROBE && write_next;
    // pins hold through a reference fall, so an accept there waits a cycle
    if (!edge_en) begin
      cs_n_next = cs_n_reg;
      ale_next = ale_reg;
      rd_n_next = rd_n_reg;
      wr_n_next = wr_n_reg;
      bhe_n_next = bhe_n_reg;
      ad_next = ad_reg;
      ad_oe_next = ad_oe_reg;
      aport_next = aport_reg;
      seg_next = seg_reg;
      seg_oe_next = seg_oe_reg;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      state_reg <= ST_IDLE;
      addr_reg <= 24'h000000;
      wdata_reg <= RDATA_RST;
      rdata_reg <= RDATA_RST;
      write_reg <= 1'b0;
      byte_reg <= 1'b0;
      win_reg <= WIN_DEFAULT;
      mode8_reg <= 1'b0;
      mux_reg <= 1'b0;
      wait_reg <= '0;
      cnt_reg <= '0;
      phase_reg <= 1'b0;
      local_reg <= 1'b0;
      ack_reg <= 1'b0;
      trap_reg <= 1'b0;
      target_reg <= TGT_EXT;
      bit_reg <= 1'b0;
      io_reg <= 1'b0;
      ref_reg <= 1'b0;
      ale_reg <= 1'b0;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      bhe_n_reg <= 1'b1;
      cs_n_reg <= 4'hF;
      ad_reg <= 16'h0000;
      ad_oe_reg <= 16'h0000;
      aport_reg <= 16'h0000;
      seg_reg <= 8'h00;
      seg_oe_reg <= 8'h00;
      lb_sel_reg <= 1'b0;
      lb_rd_reg <= 1'b0;
      lb_wr_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      write_reg <= write_next;
      byte_reg <= byte_next;
      win_reg <= win_next;
      mode8_reg <= mode8_next;
      mux_reg <= mux_next;
      wait_reg <= wait_next;
      cnt_reg <= cnt_next;
      phase_reg <= phase_next;
      local_reg <= local_next;
      ack_reg <= ack_next;
      trap_reg <= trap_next;
      target_reg <= target_next;
      bit_reg <= bit_next;
      io_reg <= io_next;
      ref_reg <= ref_next;
      ale_reg <= ale_next;
      rd_n_reg <= rd_n_next;
      wr_n_reg <= wr_n_next;
      bhe_n_reg <= bhe_n_next;
      cs_n_reg <= cs_n_next;
      ad_reg <= ad_next;
      ad_oe_reg <= ad_oe_next;
      aport_reg <= aport_next;
      seg_reg <= seg_next;
      seg_oe_reg <= seg_oe_next;
      lb_sel_reg <= lb_sel_next;
      lb_rd_reg <= lb_rd_next;
      lb_wr_reg <= lb_wr_next;
    end
  end

  // one access at a time; no queue in front of the sequencer
  assign O_READY = (state_reg == ST_IDLE);
  assign O_ACK = ack_reg;
  assign O_TRAP = trap_reg;
  assign O_RDATA = rdata_reg;
  assign O_TARGET = target_reg;
  assign O_BIT_ADDRESSABLE = bit_reg;
  assign O_NO_PIPE_OPT = io_reg;
  assign O_ADDR_DATA_PORT = ad_reg;
  assign O_ADDR_DATA_PORT_OE = ad_oe_reg;
  assign O_ADDRESS_PORT = aport_reg;
  assign O_SEG_PORT = seg_reg;
  assign O_SEG_PORT_OE = seg_oe_reg;
  assign O_CS_N = cs_n_reg;
  assign O_ALE = ale_reg;
  assign O_RD_N = rd_n_reg;
  assign O_WR_N = wr_n_reg;
  assign O_BHE_N = bhe_n_reg;
  assign O_BUS_REF_CLK = ref_reg;
  assign O_LOCAL_BUS_SEL = lb_sel_reg;
  assign O_LOCAL_BUS_RD = lb_rd_reg;
  assign O_LOCAL_BUS_WR = lb_wr_reg;
  assign O_LOCAL_BUS_ADDR = addr_reg;
  assign O_LOCAL_BUS_WDATA = wdata_reg;

endmodule : addr_map_ebu

// ===== sim/addr_map_ebu_asserts.sv
// Purpose: port-level checks for the address map and bus unit
// Assumes: internal areas answer one cycle after the request is taken
// Notes: the window 4 select is internal and never shows on a pin
`timescale 1ns/1ps
module addr_map_ebu_asserts
  import ebu_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic I_REQ,
  input wire logic [23:0] I_ADDR,
  input wire logic I_WRITE,
  input wire logic I_GPR_ACCESS,
  input wire logic I_LOCAL_BUS,
  input wire logic I_SINGLE_CHIP,
  input wire logic O_READY,
  input wire logic O_ACK,
  input wire logic O_TRAP,
  input wire logic [3:0] O_TARGET,
  input wire logic O_NO_PIPE_OPT,
  input wire logic O_BIT_ADDRESSABLE,
  input wire logic O_LOCAL_BUS_SEL,
  input wire logic [3:0] O_CS_N,
  input wire logic O_RD_N,
  input wire logic O_BUS_REF_CLK
);
  logic go;
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RST_N);
  // a decoded request is taken on this edge
  assign go = I_REQ && O_READY && !I_LOCAL_BUS;
  a_int_one_cycle: assert property (go && I_ADDR inside
    {[DATA_SRAM_START:DATA_SRAM_END]} |=> O_ACK && O_TARGET == TGT_DATA_SRAM)
    else $error("internal access not answered in one cycle");
  a_io_no_pipe: assert property (go && !I_SINGLE_CHIP && I_ADDR inside
    {[EXT_IO_START:EXT_IO_END]} |=> O_NO_PIPE_OPT [*3])
    else $error("io access left pipeline optimisation on");
  a_ext_not_early: assert property (go && !I_SINGLE_CHIP && I_ADDR
    inside {[24'h400000:EXT_HIGH_END]} |=> !O_ACK [*4])
    else $error("external access answered too early");
  a_single_trap: assert property (go && I_SINGLE_CHIP && I_ADDR
    inside {[24'h400000:EXT_HIGH_END]} |=> O_TRAP)
    else $error("single chip external access did not trap");
  a_one_select: assert property ($onehot0(~O_CS_N))
    else $error("more than one select active");
  a_idle_no_cs: assert property (O_READY && !O_ACK |-> &O_CS_N)
    else $error("select active while idle");
  a_pins_on_ref: assert property ($changed(O_RD_N) ||
    $changed(O_CS_N) |-> $rose(O_BUS_REF_CLK))
    else $error("bus pin moved off a reference clock rise");
  a_flash_wr_ok: assert property (go && I_WRITE &&
    I_ADDR >= FLASH_REG_START |=> !O_TRAP)
    else $error("flash register write trapped");
  a_bit_top: assert property (go && I_ADDR inside
    {[DUAL_PORT_RAM_BIT_START:DUAL_PORT_RAM_END]} |=> O_BIT_ADDRESSABLE)
    else $error("top dual port bytes not bit addressable");
  a_bit_gpr: assert property (go && I_GPR_ACCESS &&
    I_ADDR inside {[DUAL_PORT_RAM_START:DUAL_PORT_RAM_END]} |=> O_BIT_ADDRESSABLE)
    else $error("register bank location not bit addressable");
  a_bit_none: assert property (go && I_ADDR < DUAL_PORT_RAM_START |=>
    !O_BIT_ADDRESSABLE)
    else $error("location below dual port ram flagged bit addressable");
  a_local_sel: assert property (I_REQ && O_READY && I_LOCAL_BUS |=>
    O_LOCAL_BUS_SEL && &O_CS_N)
    else $error("local bus access not selected or leaked to pins");
endmodule : addr_map_ebu_asserts

bind addr_map_ebu addr_map_ebu_asserts chk_u (
  .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_REQ(I_REQ),
  .I_ADDR(I_ADDR), .I_WRITE(I_WRITE), .I_GPR_ACCESS(I_GPR_ACCESS),
  .I_LOCAL_BUS(I_LOCAL_BUS),
  .O_BIT_ADDRESSABLE(O_BIT_ADDRESSABLE), .O_LOCAL_BUS_SEL(O_LOCAL_BUS_SEL),
  .I_SINGLE_CHIP(I_SINGLE_CHIP), .O_READY(O_READY), .O_ACK(O_ACK),
  .O_TRAP(O_TRAP), .O_TARGET(O_TARGET), .O_NO_PIPE_OPT(O_NO_PIPE_OPT),
  .O_CS_N(O_CS_N), .O_RD_N(O_RD_N), .O_BUS_REF_CLK(O_BUS_REF_CLK)
);

// ===== sim/ext_mem_model.sv
// Purpose: external memory standing on the address and data pins
// Assumes: the bench tells the model its bus width and read delay
// Notes: released data lines show the inverse of the last value
`timescale 1ns/1ps
module ext_mem_model (
  input wire logic i_clk,
  input wire logic i_ale,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [15:0] i_adp,
  input wire logic [15:0] i_addr,
  input wire logic i_narrow,
  input wire logic [2:0] i_lat,
  output logic [15:0] o_adp
);
  logic [7:0] mem [0:511];
  logic [8:0] a;
  logic [15:0] last = 16'h0000;
  logic [15:0] data;
  logic [2:0] cnt;
  logic drive;
  // an 8-bit device answers on the low lane only
  assign data = i_narrow ? {8'h00, mem[a]} : {mem[a | 9'h001], mem[a]};
  assign drive = !i_rd_n && cnt >= i_lat;
  assign o_adp = drive ? data : ~last;
  // slow answers wait i_lat cycles into the strobe
  always @(posedge i_clk) begin
    if (i_ale) begin
      a <= (i_addr != 16'h0000) ? i_addr[8:0] : i_adp[8:0];
    end
    cnt <= i_rd_n ? 3'h0 : cnt + 3'(cnt != 3'h7);
    if (drive) begin
      last <= data;
    end
    if (!i_wr_n) begin
      mem[a] <= i_adp[7:0];
      if (!i_narrow) begin
        mem[a | 9'h001] <= i_adp[15:8];
      end
    end
  end
endmodule : ext_mem_model

// ===== sim/tb.sv
// Purpose: self-checking bench for the address map and bus unit
// Assumes: a window hits when masked address bits 23..12 match its base
// Notes: a monitor pops one expected result on every ack
`timescale 1ns/1ps
module tb;
  import ebu_pkg::*;
  typedef struct packed {
    logic [15:0] d;
    logic [3:0] t;
    logic [3:0] cs;
    logic [2:0] m;
    logic tr;
  } exp_type;
  exp_type q[$];
  exp_type r;
  int miscompares = 0;
  int cmp_count = 0;
  int seed = 84;
  logic clk, rst_n, req, wr, byt, general_register, lb, sc, nar;
  logic [2:0] lat, segl;
  logic [7:0] sego;
  logic [23:0] addr;
  logic [15:0] wdat, irdat, lbrd, mdat, pin, v, rdat, adp, adp_oe, aport;
  logic [3:0] wen, csa, tgt, cs_n;
  logic [47:0] wbase, wmask;
  logic [19:0] tset;
  logic [9:0] fset;
  logic rdy, ack, trap, ale, rd_n, wr_n;
  target_type tg [8] = '{TGT_DATA_SRAM, TGT_SFR, TGT_EXTENDED_REGISTER_SPACE, TGT_DUAL_PORT_RAM,
    TGT_DUAL_PORT_RAM, TGT_FLASH, TGT_PROGRAM_SRAM, TGT_FLASH_REG};
  logic [23:0] ia [8] = '{24'h00C010, 24'h00FE20, 24'h00F010, 24'h00F600,
    24'h00FD40, 24'hC00100, 24'hE00010, 24'hFFF010};
  logic [3:0] wl [3] = '{4'hB, 4'h0, 4'h4};
  logic [3:0] cl [3] = '{4'hF, 4'hE, 4'h7};
  // wire level of the shared lines from both drivers
  assign pin = (adp & adp_oe) | (mdat & ~adp_oe);
  addr_map_ebu dut_u (
    .I_SYS_CLK(clk), .I_RST_N(rst_n), .I_REQ(req), .I_ADDR(addr),
    .I_WRITE(wr), .I_BYTE(byt), .I_GPR_ACCESS(general_register), .I_LOCAL_BUS(lb),
    .I_WDATA(wdat), .I_INT_RDATA(irdat), .I_SINGLE_CHIP(sc),
    .I_SEG_LINES(segl), .I_WIN_ENABLE(wen), .I_WIN_BASE(wbase),
    .I_WIN_MASK(wmask), .I_TIMING_SET(tset), .I_FUNCTION_SET(fset),
    .I_ADDR_DATA_PORT(pin), .I_LOCAL_BUS_RDATA(lbrd), .O_READY(rdy),
    .O_ACK(ack), .O_TRAP(trap), .O_RDATA(rdat), .O_TARGET(tgt),
    .O_BIT_ADDRESSABLE(), .O_NO_PIPE_OPT(), .O_ADDR_DATA_PORT(adp),
    .O_ADDR_DATA_PORT_OE(adp_oe), .O_ADDRESS_PORT(aport), .O_SEG_PORT(),
    .O_SEG_PORT_OE(sego), .O_CS_N(cs_n), .O_ALE(ale), .O_RD_N(rd_n),
    .O_WR_N(wr_n), .O_BHE_N(), .O_BUS_REF_CLK(), .O_LOCAL_BUS_SEL(),
    .O_LOCAL_BUS_RD(), .O_LOCAL_BUS_WR(), .O_LOCAL_BUS_ADDR(),
    .O_LOCAL_BUS_WDATA());
  ext_mem_model mem_u (.i_clk(clk), .i_ale(ale), .i_rd_n(rd_n),
    .i_wr_n(wr_n), .i_adp(adp), .i_addr(aport), .i_narrow(nar),
    .i_lat(lat), .o_adp(mdat));
  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    cmp_count++;
    if (s !== x) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, s, x);
    end
  endtask : chk
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  // hold the request until the unit is ready and takes it
  task automatic acc(input logic [23:0] a, input logic w, input exp_type x);
    int n;
    req <= 1'b1;
    addr <= a;
    wr <= w;
    general_register <= 1'($random(seed));
    wdat <= x.d;
    irdat <= x.d;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 400);
    if (rdy !== 1'b1) begin
      miscompares++;
      give_verdict();
    end
    @(posedge clk);
    q.push_back(x);
  endtask : acc
  // drop the request and wait for every pending answer
  task automatic fin;
    int n;
    req <= 1'b0;
    n = 0;
    while (q.size() > 0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (q.size() > 0) begin
      miscompares++;
      give_verdict();
    end
  endtask : fin
  // outputs settle by the falling edge; selects are gathered per access
  always @(negedge clk) begin
    if (ack === 1'b1) begin
      if (q.size() == 0) begin
        miscompares++;
        $display("BAD %0t ack with nothing pending", $time);
      end else begin
        r = q.pop_front();
        if (r.m[2]) chk(rdat, r.d);
        if (r.m[1]) chk(16'(tgt), 16'(r.t));
        if (r.m[0]) chk(16'(csa & cs_n), 16'(r.cs));
        chk(16'(trap), 16'(r.tr));
      end
      csa = 4'hF;
    end else begin
      csa = csa & cs_n;
    end
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {rst_n, req, wr, byt, general_register, lb, sc, nar} = 8'h00;
    {addr, wdat, irdat, lbrd, wen, wbase, wmask, fset} = '0;
    tset = 20'h22422;
    lat = 3'h0;
    segl = 3'h7;
    csa = 4'hF;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // every internal area answers in one cycle, back to back
    for (int i = 0; i < 8; i++) begin
      acc(ia[i] | 24'(4'($random(seed)) & 4'hE), 1'b0,
        '{16'($random(seed)), tg[i], 4'hF, 3'b110, 1'b0});
    end
    // reserved program space and an undefined flash register trap
    acc(24'hC20000, 1'b0, '{16'h0, 4'h0, 4'hF, 3'b000, 1'b1});
    acc(FLASH_REG_START + 24'(FLASH_REG_USED_DEFAULT), 1'b0,
      '{TRAP_CODE_DEFAULT, 4'h0, 4'hF, 3'b100, 1'b1});
    acc(24'hFFF200, 1'b1, '{16'h1234, 4'h0, 4'hF, 3'b000, 1'b0});
    fin();
    sc <= 1'b1;
    acc(24'h400000, 1'b0, '{16'h0, 4'h0, 4'hF, 3'b000, 1'b1});
    fin();
    // windows 1 and 2 overlap; window 2 is slow and must win
    sc <= 1'b0;
    wbase <= {4{12'h401}};
    wmask <= 48'hFFFFFFFFFFFF;
    wen <= 4'h3;
    fset <= 10'b0010000001;
    lat <= 3'h3;
    v = 16'($random(seed));
    acc(24'h401010, 1'b1, '{v, TGT_EXT, 4'hB, 3'b011, 1'b0});
    fin();
    acc(24'h401010, 1'b0, '{v, TGT_EXT, 4'hB, 3'b111, 1'b0});
    fin();
    // window 4 hides its select, default is multiplexed, window 3 is 8-bit
    lat <= 3'h0;
    for (int i = 0; i < 3; i++) begin
      wen <= wl[i];
      nar <= (i == 2);
      acc(24'h401010, 1'b0, '{v, TGT_EXT, cl[i], 3'b111, 1'b0});
      fin();
    end
    wen <= 4'h0;
    nar <= 1'b0;
    // odd byte over the 16-bit bus comes from the high lane
    byt <= 1'b1;
    acc(24'h401011, 1'b0,
      '{{8'h00, v[15:8]}, TGT_EXT, 4'hE, 3'b111, 1'b0});
    fin();
    byt <= 1'b0;
    v = 16'($random(seed));
    acc(EXT_IO_START + 24'h20, 1'b1, '{v, TGT_EXT_IO, 4'hE, 3'b011, 1'b0});
    fin();
    acc(EXT_IO_START + 24'h20, 1'b0, '{v, TGT_EXT_IO, 4'hE, 3'b111, 1'b0});
    fin();
    // local peripheral bus goes through the same access path
    lb <= 1'b1;
    v = 16'($random(seed));
    lbrd <= v;
    acc(24'h200000 | 24'(16'($random(seed))), 1'b0,
      '{v, 4'h0, 4'hF, 3'b100, 1'b0});
    fin();
    lb <= 1'b0;
    // only the programmed count of segment lines is enabled
    segl <= 3'($random(seed));
    repeat (4) @(negedge clk);
    chk(16'(sego), 16'((16'h0001 << segl) - 16'h0001));
    give_verdict();
  end
endmodule : tb
